/* design/pdf_token_framer_consts.svh */
`ifndef PDF_TOKEN_FRAMER_CONSTS_SVH
`define PDF_TOKEN_FRAMER_CONSTS_SVH

// Register map of the software port
`define PDF_ADDR_FIFO      8'h43
`define PDF_ADDR_CTRL      8'h50
`define PDF_ADDR_STAT      8'h51

// Control register fields (bits 3:0 are the receive enables)
`define PDF_CTRL_EN_PRIME  0
`define PDF_CTRL_EN_DPRIME 1
`define PDF_CTRL_EN_PDBG   2
`define PDF_CTRL_EN_DPDBG  3
`define PDF_CTRL_TX_START  4
`define PDF_CTRL_TX_FLUSH  5
`define PDF_CTRL_RX_FLUSH  6
`define PDF_CTRL_RESET     4'h0

// Status register fields
`define PDF_STAT_TX_EMPTY  0
`define PDF_STAT_TX_FULL   1
`define PDF_STAT_RX_EMPTY  2
`define PDF_STAT_RX_FULL   3
`define PDF_STAT_TX_BUSY   4
`define PDF_STAT_DRV_ON    5
`define PDF_STAT_RX_OVF    6

// Transmit token codes
`define PDF_TOK_PACKED_TOP 3'h4
`define PDF_TOK_CRC        8'hff
`define PDF_TOK_EOP        8'h14
`define PDF_TOK_DRV_OFF    8'hfe
`define PDF_TOK_SYNC1      8'h12
`define PDF_TOK_SYNC2      8'h13
`define PDF_TOK_SYNC3      8'h1b
`define PDF_TOK_RST1       8'h15
`define PDF_TOK_RST2       8'h16
`define PDF_TOK_TXON       8'ha1
`define PDF_TOK_TXON_MASK  8'he1

// Receive type token top bits
`define PDF_RXT_SOP        3'h7
`define PDF_RXT_PRIME      3'h6
`define PDF_RXT_DPRIME     3'h5
`define PDF_RXT_PDBG       3'h4
`define PDF_RXT_DPDBG      3'h3

// Line symbols after 4b5b coding
`define PDF_K_SYNC1        5'h18
`define PDF_K_SYNC2        5'h11
`define PDF_K_SYNC3        5'h06
`define PDF_K_RST1         5'h07
`define PDF_K_RST2         5'h19
`define PDF_K_EOP          5'h0d
`define PDF_4B5B_TABLE     80'hef37abda727b96aad13e

// Packet checksum
`define PDF_CRC_INIT       32'hffffffff
`define PDF_CRC_POLY       32'hedb88320

// Queue geometry
`define PDF_QUEUE_WORDS    80
`define PDF_QUEUE_DEPTH    7'd80
`define PDF_QUEUE_LAST     7'd79

`endif

/* design/pdf_pkg.sv */
package pdf_pkg;
`include "pdf_token_framer_consts.svh"

	// Transmit engine states
	typedef enum logic [4:0] {
		PDF_TX_IDLE   = 5'h01,
		PDF_TX_FETCH  = 5'h02,
		PDF_TX_DATA   = 5'h04,
		PDF_TX_NIB_HI = 5'h08,
		PDF_TX_CRC    = 5'h10
	} pdf_tx_state_t;

	// Start-of-packet kinds reported by the receiver
	typedef enum logic [2:0] {
		PDF_SOP_PLAIN  = 3'h0,
		PDF_SOP_PRIME  = 3'h1,
		PDF_SOP_DPRIME = 3'h2,
		PDF_SOP_PDBG   = 3'h3,
		PDF_SOP_DPDBG  = 3'h4
	} pdf_sop_kind_t;

	// Byte queue state
	typedef struct packed {
		logic [`PDF_QUEUE_WORDS-1:0][7:0] mem;
		logic [6:0]                       wr_ptr;
		logic [6:0]                       rd_ptr;
		logic [6:0]                       count;
	} pdf_queue_t;

	// Framer state
	typedef struct packed {
		pdf_tx_state_t tx_st;
		logic [4:0]    cnt;
		logic [3:0]    hi_nib;
		logic [2:0]    crc_nib;
		logic [31:0]   crc;
		logic [31:0]   crc_out;
		logic          sym_valid;
		logic [4:0]    sym_code;
		logic          drv_en;
		logic [3:0]    rx_en;
		logic          rx_act;
		logic          rx_ovf;
		logic [4:0]    wr_pend;
		logic [7:0]    rdata;
	} pdf_frm_t;
endpackage

/* design/pdf_queue_if.sv */
`timescale 1ns/1ps
interface pdf_queue_if;
	logic       push;
	logic [7:0] wdata;
	logic       pop;
	logic       clear;
	logic [7:0] rdata;
	logic       empty;
	logic       full;
	logic [6:0] level;

	// Queue side
	modport queue (
		input  push, wdata, pop, clear,
		output rdata, empty, full, level
	);

	// User side
	modport user (
		output push, wdata, pop, clear,
		input  rdata, empty, full, level
	);
endinterface

/* design/pdf_byte_queue.sv */
`timescale 1ns/1ps
`include "pdf_token_framer_consts.svh"
module pdf_byte_queue
	import pdf_pkg::*;
(
	// Clock and reset
	input  wire logic  i_clk_sys,
	input  wire logic  i_sys_rst,
	// Queue port
	pdf_queue_if.queue q
);
	pdf_queue_t st;
	pdf_queue_t nx;

	// Head is shown ahead so a pop can use it in the same cycle
	assign q.rdata = st.mem[st.rd_ptr];
	assign q.empty = (st.count == 7'h00);
	assign q.full  = (st.count == `PDF_QUEUE_DEPTH);
	assign q.level = st.count;

	// Push is refused when full, so unread data is never overwritten
	always_comb begin
		nx = st;
		if (q.clear) begin
			nx.wr_ptr = 7'h00;
			nx.rd_ptr = 7'h00;
			nx.count  = 7'h00;
		end else begin
			if (q.push && !q.full) begin
				nx.mem[st.wr_ptr] = q.wdata;
				nx.wr_ptr = (st.wr_ptr == `PDF_QUEUE_LAST) ? 7'h00
					: st.wr_ptr + 7'h01;
			end
			if (q.pop && !q.empty) begin
				nx.rd_ptr = (st.rd_ptr == `PDF_QUEUE_LAST) ? 7'h00
					: st.rd_ptr + 7'h01;
			end
			nx.count = st.count + 7'((q.push && !q.full) ? 1 : 0)
				- 7'((q.pop && !q.empty) ? 1 : 0);
		end
	end

	// State register
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end
endmodule // pdf_byte_queue

/* design/pdf_token_framer.sv */
`timescale 1ns/1ps
`include "pdf_token_framer_consts.svh"
// Function
// [R01] Top bits 100 mark a packed-data token; low five bits count bytes.
// [R02] Writer places exactly N data bytes right after the packed token.
// [R03] Writer keeps the packed byte count within 2 to 30.
// [R04] Each data byte goes out low nibble first, both 4b5b coded.
// [R05] Token 0xFF inserts the hardware CRC of the packet.
// [R06] Token 0x14 sends the end-of-packet symbol.
// [R07] Token 0xFE switches the transmit line driver off.
// [R08] Writer should place driver-off right after end-of-packet.
// [R09] Receive queue holds 80 bytes: several packets with type tokens.
// [R10] Plain SOP packet opens with type token 111, low bits zero.
// [R11] SOP' packet opens with 110, stored only when enabled.
// [R12] SOP'' packet opens with 101, stored only when enabled.
// [R13] SOP' debug packet opens with 100, stored only when enabled.
// [R14] SOP'' debug packet opens with 011, stored only when enabled.
// [R15] Type codes 010, 001, 000 are reserved; readers give them no meaning.
// [R16] One token at a time is taken and finished before the next.
// [R17] Register 43h pushes transmit bytes on write, pops receive on read.
// [R18] Tokens 0x12, 0x13, 0x1B send Sync-1, Sync-2, Sync-3.
// [R19] Reserved transmit bits are written zero; receive ones ignored.
// [R20] Bytes follow the type token in order; a full queue drops more.
module pdf_token_framer
	import pdf_pkg::*;
(
	// Clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_sys_rst,
	// Register port
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	// Transmit symbol stream to the line coder
	input  wire logic       i_sym_ready,
	output logic            o_sym_valid,
	output logic      [4:0] o_sym_code,
	output logic            o_drv_en,
	// Decoded receive stream
	input  wire logic       i_rx_sop_valid,
	input  wire logic [2:0] i_rx_sop_kind,
	input  wire logic       i_rx_byte_valid,
	input  wire logic [7:0] i_rx_byte,
	input  wire logic       i_rx_end
);
	pdf_frm_t    st;
	pdf_frm_t    nx;
	pdf_queue_if tx_q ();
	pdf_queue_if rx_q ();

	logic       tx_push;
	logic       tx_pop;
	logic       tx_clear;
	logic       rx_push;
	logic       rx_pop;
	logic       rx_clear;
	logic [7:0] rx_wdata;
	logic       start;
	logic       free;
	logic       emit;
	logic [4:0] emit_code;
	logic       rx_ok;
	logic [2:0] rx_top;
	logic [7:0] tok;

	// Both queues share one structure; the receive one is the 80-byte store
	pdf_byte_queue u_tx_queue (
		.i_clk_sys (i_clk_sys),
		.i_sys_rst (i_sys_rst),
		.q         (tx_q.queue)
	);

	// [R09] 80-byte store
	pdf_byte_queue u_rx_queue (
		.i_clk_sys (i_clk_sys),
		.i_sys_rst (i_sys_rst),
		.q         (rx_q.queue)
	);

	// Queue hookups
	assign tx_q.push  = tx_push;
	assign tx_q.wdata = i_wdata;
	assign tx_q.pop   = tx_pop;
	assign tx_q.clear = tx_clear;
	assign rx_q.push  = rx_push;
	assign rx_q.wdata = rx_wdata;
	assign rx_q.pop   = rx_pop;
	assign rx_q.clear = rx_clear;

	// Outputs are all taken from the state register
	assign o_rdata     = st.rdata;
	assign o_sym_valid = st.sym_valid;
	assign o_sym_code  = st.sym_code;
	assign o_drv_en    = st.drv_en;

	// 4b5b coding of one nibble
	function automatic logic [4:0] enc4b5b(input logic [3:0] n);
		logic [79:0] tbl;
		tbl = `PDF_4B5B_TABLE;
		return 5'(tbl >> (5 * n));
	endfunction

	// Reflected CRC-32 update over one byte, least significant bit first
	function automatic logic [31:0] crc_byte(input logic [31:0] c,
		input logic [7:0] b);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (r[0] ^ b[i]) begin
				r = (r >> 1) ^ `PDF_CRC_POLY;
			end else begin
				r = r >> 1;
			end
		end
		return r;
	endfunction

	// Receive type lookup; unknown kinds are never stored
	always_comb begin
		rx_ok  = 1'b0;
		rx_top = `PDF_RXT_SOP;
		case (i_rx_sop_kind)
			// [R10] plain packets pass without any enable
			PDF_SOP_PLAIN: begin
				rx_ok  = 1'b1;
				rx_top = `PDF_RXT_SOP;
			end
			// [R11] gated by enable
			PDF_SOP_PRIME: begin
				rx_ok  = st.rx_en[`PDF_CTRL_EN_PRIME];
				rx_top = `PDF_RXT_PRIME;
			end
			// [R12] gated by enable
			PDF_SOP_DPRIME: begin
				rx_ok  = st.rx_en[`PDF_CTRL_EN_DPRIME];
				rx_top = `PDF_RXT_DPRIME;
			end
			// [R13] gated by enable
			PDF_SOP_PDBG: begin
				rx_ok  = st.rx_en[`PDF_CTRL_EN_PDBG];
				rx_top = `PDF_RXT_PDBG;
			end
			// [R14] gated by enable
			PDF_SOP_DPDBG: begin
				rx_ok  = st.rx_en[`PDF_CTRL_EN_DPDBG];
				rx_top = `PDF_RXT_DPDBG;
			end
			// [R15] reserved codes are never produced
			default: begin
				rx_ok  = 1'b0;
				rx_top = `PDF_RXT_SOP;
			end
		endcase
	end

	// Register port, transmit engine and receive storage
	always_comb begin
		nx        = st;
		tx_push   = 1'b0;
		tx_pop    = 1'b0;
		tx_clear  = 1'b0;
		rx_push   = 1'b0;
		rx_pop    = 1'b0;
		rx_clear  = 1'b0;
		rx_wdata  = 8'h00;
		start     = 1'b0;
		emit      = 1'b0;
		emit_code = 5'h00;
		tok       = tx_q.rdata;
		nx.rdata  = 8'h00;

		// Writes; the start command is spotted only between packed runs,
		// otherwise a data byte that looks like it would start the engine
		if (i_wr) begin
			case (i_addr)
				// [R17] write pushes the transmit queue
				`PDF_ADDR_FIFO: begin
					if (st.wr_pend == 5'h00 && (i_wdata & `PDF_TOK_TXON_MASK)
						== `PDF_TOK_TXON) begin
						start = 1'b1;
					end else begin
						tx_push = 1'b1;
						if (st.wr_pend != 5'h00) begin
							nx.wr_pend = st.wr_pend - 5'h01;
						end else if (i_wdata[7:5] == `PDF_TOK_PACKED_TOP) begin
							nx.wr_pend = i_wdata[4:0];
						end
					end
				end
				`PDF_ADDR_CTRL: begin
					nx.rx_en = i_wdata[3:0];
					start    = i_wdata[`PDF_CTRL_TX_START];
					tx_clear = i_wdata[`PDF_CTRL_TX_FLUSH];
					rx_clear = i_wdata[`PDF_CTRL_RX_FLUSH];
					if (tx_clear) begin
						nx.wr_pend = 5'h00;
					end
				end
				`PDF_ADDR_STAT: begin
					if (i_wdata[`PDF_STAT_RX_OVF]) begin
						nx.rx_ovf = 1'b0;
					end
				end
				default: begin
					nx.wr_pend = nx.wr_pend;
				end
			endcase
		end

		// Reads answer in the next cycle; unmapped reads give zero
		if (i_rd) begin
			case (i_addr)
				// [R17] read pops the receive queue
				`PDF_ADDR_FIFO: begin
					nx.rdata = rx_q.empty ? 8'h00 : rx_q.rdata;
					rx_pop   = 1'b1;
				end
				`PDF_ADDR_CTRL: nx.rdata = {4'h0, st.rx_en};
				`PDF_ADDR_STAT: nx.rdata = {1'b0, st.rx_ovf, st.drv_en,
					st.tx_st != PDF_TX_IDLE, rx_q.full, rx_q.empty,
					tx_q.full, tx_q.empty};
				default: nx.rdata = 8'h00;
			endcase
		end

		// Output slot frees when empty or being taken by the line coder
		free = !st.sym_valid || i_sym_ready;
		if (st.sym_valid && i_sym_ready) begin
			nx.sym_valid = 1'b0;
		end

		case (st.tx_st)
			PDF_TX_IDLE: begin
				if (start) begin
					nx.drv_en = 1'b1;
					nx.crc    = `PDF_CRC_INIT;
					nx.tx_st  = PDF_TX_FETCH;
				end
			end
			// [R16] next token only once the slot is free
			PDF_TX_FETCH: begin
				if (!tx_q.empty && free) begin
					// [R01] packed-data token
					if (tok[7:5] == `PDF_TOK_PACKED_TOP) begin
						tx_pop = 1'b1;
						nx.cnt = tok[4:0];
						if (tok[4:0] != 5'h00) begin
							nx.tx_st = PDF_TX_DATA;
						end
					end else begin
						case (tok)
							// [R05] freeze and send the checksum
							`PDF_TOK_CRC: begin
								tx_pop     = 1'b1;
								nx.crc_out = ~st.crc;
								nx.crc_nib = 3'h0;
								nx.tx_st   = PDF_TX_CRC;
							end
							// [R18] sync symbols open a packet
							`PDF_TOK_SYNC1: begin
								tx_pop    = 1'b1;
								emit      = 1'b1;
								emit_code = `PDF_K_SYNC1;
								nx.crc    = `PDF_CRC_INIT;
							end
							`PDF_TOK_SYNC2: begin
								tx_pop    = 1'b1;
								emit      = 1'b1;
								emit_code = `PDF_K_SYNC2;
								nx.crc    = `PDF_CRC_INIT;
							end
							`PDF_TOK_SYNC3: begin
								tx_pop    = 1'b1;
								emit      = 1'b1;
								emit_code = `PDF_K_SYNC3;
								nx.crc    = `PDF_CRC_INIT;
							end
							`PDF_TOK_RST1: begin
								tx_pop    = 1'b1;
								emit      = 1'b1;
								emit_code = `PDF_K_RST1;
							end
							`PDF_TOK_RST2: begin
								tx_pop    = 1'b1;
								emit      = 1'b1;
								emit_code = `PDF_K_RST2;
							end
							// [R06] end-of-packet symbol
							`PDF_TOK_EOP: begin
								tx_pop    = 1'b1;
								emit      = 1'b1;
								emit_code = `PDF_K_EOP;
							end
							// [R07] driver off once the last symbol has left
							`PDF_TOK_DRV_OFF: begin
								if (!st.sym_valid) begin
									tx_pop    = 1'b1;
									nx.drv_en = 1'b0;
									nx.tx_st  = PDF_TX_IDLE;
								end
							end
							// Unknown tokens are consumed and ignored
							default: tx_pop = 1'b1;
						endcase
					end
				end
			end
			// [R02] waits for the data byte the writer owes
			PDF_TX_DATA: begin
				if (!tx_q.empty && free) begin
					tx_pop    = 1'b1;
					nx.crc    = crc_byte(st.crc, tok);
					nx.hi_nib = tok[7:4];
					// [R04] low nibble first
					emit      = 1'b1;
					emit_code = enc4b5b(tok[3:0]);
					nx.tx_st  = PDF_TX_NIB_HI;
				end
			end
			PDF_TX_NIB_HI: begin
				if (free) begin
					// [R04] then the high nibble
					emit      = 1'b1;
					emit_code = enc4b5b(st.hi_nib);
					nx.cnt    = st.cnt - 5'h01;
					nx.tx_st  = (st.cnt == 5'h01) ? PDF_TX_FETCH : PDF_TX_DATA;
				end
			end
			// [R05] eight coded nibbles, low first
			PDF_TX_CRC: begin
				if (free) begin
					emit       = 1'b1;
					emit_code  = enc4b5b(st.crc_out[{st.crc_nib, 2'b00} +: 4]);
					nx.crc_nib = st.crc_nib + 3'h1;
					if (st.crc_nib == 3'h7) begin
						nx.tx_st = PDF_TX_FETCH;
					end
				end
			end
			default: nx.tx_st = PDF_TX_IDLE;
		endcase

		if (emit) begin
			nx.sym_valid = 1'b1;
			nx.sym_code  = emit_code;
		end

		// Flushing the transmit queue aborts the frame and drops the driver
		if (tx_clear) begin
			nx.tx_st     = PDF_TX_IDLE;
			nx.drv_en    = 1'b0;
			nx.sym_valid = 1'b0;
		end

		// Receive: type token first, then bytes in order; overflow is
		// sticky and its set wins over a same-cycle clear
		if (i_rx_sop_valid) begin
			nx.rx_act = rx_ok && !rx_q.full;
			if (rx_ok) begin
				if (rx_q.full) begin
					nx.rx_ovf = 1'b1;
				end else begin
					// [R10] unused low bits stored as zero
					rx_push  = 1'b1;
					rx_wdata = {rx_top, 5'h00};
				end
			end
		end else if (i_rx_byte_valid && st.rx_act) begin
			// [R20] full queue keeps unread data
			if (rx_q.full) begin
				nx.rx_ovf = 1'b1;
			end else begin
				rx_push  = 1'b1;
				rx_wdata = i_rx_byte;
			end
		end
		if (i_rx_end || rx_clear) begin
			nx.rx_act = 1'b0;
		end
	end

	// State register
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			st       <= '0;
			st.tx_st <= PDF_TX_IDLE;
		end else begin
			st <= nx;
		end
	end
endmodule // pdf_token_framer

/* verif/pdf_line_model.sv */
`timescale 1ns/1ps
module pdf_line_model (
	// Clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_sys_rst,
	// Symbol stream from the framer
	input  wire logic       i_sym_valid,
	input  wire logic [4:0] i_sym_code,
	input  wire logic       i_slow,
	output logic            o_sym_ready
);
	logic [4:0] syms [0:31];
	int         n;

	// Slow mode stalls every other cycle, so held symbols are exercised
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_sym_ready <= 1'b0;
			n <= 0;
		end else begin
			o_sym_ready <= i_slow ? ~o_sym_ready : 1'b1;
			if (i_sym_valid && o_sym_ready && n < 32) begin
				syms[n] <= i_sym_code;
				n <= n + 1;
			end
		end
	end
endmodule // pdf_line_model

/* verif/pdf_token_framer_chk.sv */
`timescale 1ns/1ps
`include "pdf_token_framer_consts.svh"
module pdf_token_framer_chk (
	// Clock and reset
	input wire logic       i_clk_sys,
	input wire logic       i_sys_rst,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	// Symbol stream
	input wire logic       i_sym_ready,
	input wire logic       o_sym_valid,
	input wire logic [4:0] o_sym_code,
	input wire logic       o_drv_en
);
	logic start_w;
	logic flush_w;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);

	// Control writes; flush wins over start
	assign start_w = i_wr && i_addr == `PDF_ADDR_CTRL && i_wdata[5:4] == 2'h1;
	assign flush_w = i_wr && i_addr == `PDF_ADDR_CTRL && i_wdata[5];

	sequence s_stall;
		o_sym_valid && !i_sym_ready && !flush_w;
	endsequence
	sequence s_cold_start;
		!o_drv_en && start_w;
	endsequence

	chk_rdata_quiet: assert property (
		!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside reply cycle");
	chk_unmapped_zero: assert property (
		i_rd && !(i_addr inside {8'h43, 8'h50, 8'h51}) |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_sym_hold: assert property (
		s_stall |=> o_sym_valid && $stable(o_sym_code))
		else $error("symbol dropped before taken");
	chk_sym_drv: assert property (
		o_sym_valid |-> o_drv_en)
		else $error("symbol with driver off");
	chk_start_drv: assert property (
		start_w |=> o_drv_en)
		else $error("driver not on after start");
	chk_start_gap: assert property (
		s_cold_start |=> !o_sym_valid)
		else $error("symbol too early after start");
	chk_flush_off: assert property (
		flush_w |=> !o_drv_en && !o_sym_valid)
		else $error("flush left engine running");
	chk_drv_fall: assert property (
		$fell(o_drv_en) |-> !$past(o_sym_valid) || $past(flush_w))
		else $error("driver off with symbol pending");
endmodule // pdf_token_framer_chk

bind pdf_token_framer pdf_token_framer_chk u_chk (
	.i_clk_sys, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
	.i_sym_ready, .o_sym_valid, .o_sym_code, .o_drv_en
);

/* verif/testbench.sv */
`timescale 1ns/1ps
`include "pdf_token_framer_consts.svh"
module testbench;
	import pdf_pkg::*;
	localparam logic [79:0] TBL = `PDF_4B5B_TABLE;
	localparam logic [7:0] TOK [0:8] = '{8'h12, 8'h13, 8'h1b, 8'h82,
		8'h21, 8'hc4, 8'hff, 8'h14, 8'hfe};
	logic       i_clk_sys       = 1'b0;
	logic       i_sys_rst       = 1'b1;
	logic [7:0] i_addr          = 8'h00;
	logic [7:0] i_wdata         = 8'h00;
	logic       i_wr            = 1'b0;
	logic       i_rd            = 1'b0;
	logic [7:0] o_rdata;
	logic       i_sym_ready;
	logic       o_sym_valid;
	logic [4:0] o_sym_code;
	logic       o_drv_en;
	logic       i_rx_sop_valid  = 1'b0;
	logic [2:0] i_rx_sop_kind   = 3'h0;
	logic       i_rx_byte_valid = 1'b0;
	logic [7:0] i_rx_byte       = 8'h00;
	logic       i_rx_end        = 1'b0;
	logic       slow            = 1'b0;
	int         n_mismatch      = 0;
	int         compares        = 0;

	pdf_token_framer u_dut (.i_clk_sys, .i_sys_rst, .i_addr, .i_wdata,
		.i_wr, .i_rd, .o_rdata, .i_sym_ready, .o_sym_valid, .o_sym_code,
		.o_drv_en, .i_rx_sop_valid, .i_rx_sop_kind, .i_rx_byte_valid,
		.i_rx_byte, .i_rx_end);
	pdf_line_model u_line (.i_clk_sys, .i_sys_rst, .i_sym_valid(o_sym_valid),
		.i_sym_code(o_sym_code), .i_slow(slow), .o_sym_ready(i_sym_ready));

	// 125 MHz core clock
	initial begin
		forever #4 i_clk_sys = ~i_clk_sys;
	end

	task wrap_up;
		if (n_mismatch == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task cmp(input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			$display("unexpected at %0t: exp %h got %h", $time, exp, got);
			n_mismatch++;
		end
	endtask

	// Bus cycles start after an edge, so strobes never double up
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk_sys);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		@(posedge i_clk_sys);
		d = o_rdata;
	endtask

	// One received packet: start, bytes tagged by kind, end
	task rx(input logic [2:0] k, input int nb);
		@(posedge i_clk_sys);
		i_rx_sop_valid <= 1'b1;
		i_rx_sop_kind <= k;
		@(posedge i_clk_sys);
		i_rx_sop_valid <= 1'b0;
		for (int j = 0; j < nb; j++) begin
			i_rx_byte_valid <= 1'b1;
			// Offset by one so a stored byte never reads like an empty queue
			i_rx_byte <= 8'(j + 1) ^ {k, 5'h00};
			@(posedge i_clk_sys);
		end
		i_rx_byte_valid <= 1'b0;
		i_rx_end <= 1'b1;
		@(posedge i_clk_sys);
		i_rx_end <= 1'b0;
	endtask

	function automatic logic [31:0] crc8(logic [31:0] c, logic [7:0] b);
		c = c ^ {24'h0, b};
		for (int k = 0; k < 8; k++) begin
			c = c[0] ? (c >> 1) ^ `PDF_CRC_POLY : c >> 1;
		end
		return c;
	endfunction

	// Bounded wait for the engine to drop the driver at the end of a frame
	task wait_drv_off;
		int i;
		repeat (2) @(posedge i_clk_sys);
		for (i = 0; i < 500 && o_drv_en !== 1'b0; i++) @(posedge i_clk_sys);
		if (i == 500) begin
			n_mismatch++;
			wrap_up;
		end
	endtask

	task t_regs;
		logic [7:0] d;
		rd(`PDF_ADDR_STAT, d);
		cmp(8'h05, d);
		wr(8'h60, 8'h0f);
		rd(8'h60, d);
		cmp(8'h00, d);
		rd(`PDF_ADDR_CTRL, d);
		cmp(8'h00, d);
		wr(`PDF_ADDR_CTRL, 8'h20);
	endtask

	task t_tx;
		logic [4:0]  ex [0:15];
		logic [31:0] c;
		logic [7:0]  d;
		int          i;
		c = ~crc8(crc8(`PDF_CRC_INIT, 8'h21), 8'hc4);
		ex[0] = `PDF_K_SYNC1;
		ex[1] = `PDF_K_SYNC2;
		ex[2] = `PDF_K_SYNC3;
		ex[3] = TBL[5+:5];
		ex[4] = TBL[10+:5];
		ex[5] = TBL[20+:5];
		ex[6] = TBL[60+:5];
		for (i = 0; i < 8; i++) ex[7+i] = TBL[5*c[4*i+:4]+:5];
		ex[15] = `PDF_K_EOP;
		slow <= 1'b1;
		for (i = 0; i < 9; i++) wr(`PDF_ADDR_FIFO, TOK[i]);
		wr(`PDF_ADDR_CTRL, 8'h10);
		wait_drv_off;
		cmp(8'd16, 8'(u_line.n));
		for (i = 0; i < 16; i++) begin
			cmp(8'(ex[i]), 8'(u_line.syms[i]));
		end
		rd(`PDF_ADDR_STAT, d);
		cmp(8'h01, d & 8'h31);
		slow <= 1'b0;
	endtask

	// In-queue start command; a run byte shaped like it must stay data
	task t_txon;
		logic [7:0] d;
		// First run byte looks like start
		wr(`PDF_ADDR_FIFO, `PDF_TOK_RST1);
		wr(`PDF_ADDR_FIFO, `PDF_TOK_RST2);
		wr(`PDF_ADDR_FIFO, 8'h82);
		wr(`PDF_ADDR_FIFO, 8'ha1);
		wr(`PDF_ADDR_FIFO, 8'h3c);
		wr(`PDF_ADDR_FIFO, `PDF_TOK_EOP);
		wr(`PDF_ADDR_FIFO, `PDF_TOK_DRV_OFF);
		wr(`PDF_ADDR_FIFO, `PDF_TOK_TXON);
		wait_drv_off;
		cmp(8'd23, 8'(u_line.n));
		cmp(8'(`PDF_K_RST1), 8'(u_line.syms[16]));
		cmp(8'(`PDF_K_RST2), 8'(u_line.syms[17]));
		cmp(8'(TBL[5+:5]), 8'(u_line.syms[18]));
		cmp(8'(TBL[50+:5]), 8'(u_line.syms[19]));
		cmp(8'(TBL[60+:5]), 8'(u_line.syms[20]));
		cmp(8'(TBL[15+:5]), 8'(u_line.syms[21]));
		cmp(8'(`PDF_K_EOP), 8'(u_line.syms[22]));
		rd(`PDF_ADDR_STAT, d);
		cmp(8'h01, d & 8'h31);
	endtask

	task t_rx_types;
		logic [7:0] d;
		wr(`PDF_ADDR_CTRL, 8'h0f);
		rd(`PDF_ADDR_CTRL, d);
		cmp(8'h0f, d);
		for (int k = 0; k < 5; k++) rx(3'(k), 1);
		// Only the top bits carry meaning
		for (int k = 0; k < 5; k++) begin
			rd(`PDF_ADDR_FIFO, d);
			cmp(8'(7 - k), 8'(d[7:5]));
			rd(`PDF_ADDR_FIFO, d);
			cmp({3'(k), 5'h01}, d);
		end
		wr(`PDF_ADDR_CTRL, 8'h00);
		for (int k = 4; k >= 0; k--) rx(3'(k), 1);
		rd(`PDF_ADDR_FIFO, d);
		cmp(8'h07, {5'h0, d[7:5]});
		rd(`PDF_ADDR_FIFO, d);
		cmp(8'h01, d);
		rd(`PDF_ADDR_STAT, d);
		cmp(8'h04, d & 8'h04);
	endtask

	task t_rx_full;
		logic [7:0] d;
		rx(3'h0, 90);
		rd(`PDF_ADDR_STAT, d);
		cmp(8'h48, d & 8'h4c);
		rd(`PDF_ADDR_FIFO, d);
		cmp(8'h07, {5'h0, d[7:5]});
		for (int j = 0; j < 79; j++) begin
			rd(`PDF_ADDR_FIFO, d);
			cmp(8'(j + 1), d);
		end
		rd(`PDF_ADDR_STAT, d);
		cmp(8'h04, d & 8'h0c);
		// Overflow is sticky until software writes its bit back
		wr(`PDF_ADDR_STAT, 8'h40);
		rd(`PDF_ADDR_STAT, d);
		cmp(8'h00, d & 8'h40);
		// Receive flush empties a queue that holds a packet
		rx(3'h0, 2);
		rd(`PDF_ADDR_STAT, d);
		cmp(8'h00, d & 8'h0c);
		wr(`PDF_ADDR_CTRL, 8'h40);
		rd(`PDF_ADDR_STAT, d);
		cmp(8'h04, d & 8'h0c);
	endtask

	// Reset for ten cycles, then the scenarios in turn
	initial begin
		repeat (10) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		t_regs;
		t_tx;
		t_txon;
		t_rx_types;
		t_rx_full;
		wrap_up;
	end
endmodule // testbench
